// ==== sec_array.sv ====
// byte array storage with a masked whole-page write port
`timescale 1ns/10ps
module sec_array #(
	parameter int ADDR_W = 8,
	parameter int PAGE_W = 4
) (
	input  wire logic                         clk,
	input  wire logic                         we,
	input  wire logic [ADDR_W-PAGE_W-1:0]     page,
	input  wire logic [(1<<PAGE_W)*8-1:0]     wdata,
	input  wire logic [(1<<PAGE_W)-1:0]       wmask,
	input  wire logic [ADDR_W-1:0]            rd_idx,
	output logic      [7:0]                   rd_data
);
	import sec_pkg::*;

	localparam int PAGE_N = 1 << PAGE_W;

	if (PAGE_W < 1 || PAGE_W >= ADDR_W) begin : g_chk
		$error("sec_array: page width must lie between 1 and ADDR_W-1");
	end

	logic [7:0] mem_reg [1<<ADDR_W];

	// page write, one byte lane per mask bit
	always_ff @(posedge clk) begin
		for (int i = 0; i < PAGE_N; i++) begin
			if (we && wmask[i]) begin
				mem_reg[{page, PAGE_W'(i)}] <= wdata[i*8 +: 8];
			end
		end
	end

	assign rd_data = mem_reg[rd_idx];
endmodule : sec_array

// ==== sec_core.sv ====
// serial eeprom command decoder, status register and write protection
`timescale 1ns/10ps
`include "sec_map.svh"
module sec_core #(
	parameter int WR_CYCLES = `SEC_WR_TIME_US * `SEC_MCLK_KHZ / 1000
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic si,
	input  wire logic wp_n,
	output logic      so,
	output logic      so_oe
);
	import sec_pkg::*;

	localparam int CNT_W = $clog2(WR_CYCLES + 1);

	if (WR_CYCLES < 1) begin : g_chk
		$error("sec_core: WR_CYCLES must be at least one");
	end

	// state held in the system clock domain
	logic                 latch_reg;
	logic [1:0]           bp_reg;
	logic                 hw_en_reg;
	sec_state_e           state_reg;
	logic [CNT_W-1:0]     cnt_reg;
	logic                 pend_v_reg;
	logic [1:0]           pend_bp_reg;
	logic                 pend_hwen_reg;
	logic                 cs_m1_reg;
	logic                 cs_s2_reg;
	logic                 cs_s3_reg;
	logic                 tog_m1_reg;
	logic                 tog_s2_reg;
	logic                 tog_seen_reg;
	logic                 wp_m1_reg;
	logic                 wp_s2_reg;

	// link domain frame state, cleared while chip select is high
	logic                 frame_rst_n;
	logic [2:0]           bit_cnt_reg;
	logic [6:0]           rx_reg;
	logic [1:0]           phase_reg;
	logic                 so_reg;
	logic                 so_oe_reg;

	// link domain command record, stable after chip select rises
	sec_cmd_e             cmd_reg;
	logic                 tog_reg;
	logic [7:0]           addr_reg;
	logic [7:0]           stat_data_reg;
	logic                 stat_got_reg;
	logic [15:0][7:0]     page_reg;
	logic [15:0]          mask_reg;
	logic [3:0]           col_reg;
	logic [3:0]           page_base_reg;
	logic [7:0]           out_byte_reg;
	logic                 busy_m1_reg;
	logic                 busy_s2_reg;

	logic [7:0]           rx_byte;
	logic                 byte_done;
	sec_cmd_e             dec_cmd;
	logic [7:0]           st_now;
	logic [7:0]           rd_idx;
	logic [7:0]           rd_data;
	logic                 tx_on;
	logic                 busy;
	logic                 hw_prot;
	logic                 cs_rise;
	logic                 go;
	logic                 hw_guard_enable_ok;
	logic                 start_stat;
	logic                 start_arr;
	logic                 finish;
	logic [15:0]          wmask;

	// link side: shift register and bit counter
	assign frame_rst_n = rst_n & ~cs_n;
	assign rx_byte     = {rx_reg, si};
	assign byte_done   = (bit_cnt_reg == 3'h7);
	assign dec_cmd     = sec_decode(rx_byte);

	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_reg <= 3'h0;
			rx_reg      <= 7'h00;
			phase_reg   <= 2'h0;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			rx_reg      <= rx_byte[6:0];
			if (byte_done && phase_reg != 2'h3) begin
				phase_reg <= phase_reg + 2'h1;
			end
		end
	end

	// busy level brought into the link domain
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			busy_m1_reg <= 1'b0;
			busy_s2_reg <= 1'b0;
		end else begin
			busy_m1_reg <= busy;
			busy_s2_reg <= busy_m1_reg;
		end
	end

	// status image as seen on the serial output
	always_comb begin
		st_now                    = 8'h00;
		st_now[`SEC_ST_LATCH_BIT] = latch_reg;
		st_now[`SEC_ST_BP_LO_BIT] = bp_reg[0];
		st_now[`SEC_ST_BP_HI_BIT] = bp_reg[1];
		st_now[`SEC_ST_HWEN_BIT]  = hw_en_reg;
		if (busy_s2_reg) begin
			st_now = `SEC_ST_BUSY_VAL;
		end
	end

	assign rd_idx = (phase_reg == 2'h1) ? rx_byte : addr_reg;

	// opcode capture
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			cmd_reg <= SEC_CMD_NONE;
			tog_reg <= 1'b0;
		end else if (byte_done && phase_reg == 2'h0) begin
			tog_reg <= ~tog_reg;
			if (busy_s2_reg && dec_cmd != SEC_CMD_STATUS_READ) begin
				cmd_reg <= SEC_CMD_NONE;
			end else begin
				cmd_reg <= dec_cmd;
			end
		end
	end

	// operand bytes and page assembly
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			addr_reg      <= 8'h00;
			stat_data_reg <= 8'h00;
			stat_got_reg  <= 1'b0;
			page_reg      <= '0;
			mask_reg      <= 16'h0000;
			col_reg       <= 4'h0;
			page_base_reg <= 4'h0;
		end else if (byte_done) begin
			if (phase_reg == 2'h0) begin
				mask_reg     <= 16'h0000;
				stat_got_reg <= 1'b0;
			end else if (phase_reg == 2'h1) begin
				case (cmd_reg)
					SEC_CMD_STATUS_WRITE: begin
						stat_data_reg <= rx_byte;
						stat_got_reg  <= 1'b1;
					end
					SEC_CMD_ARRAY_READ: begin
						addr_reg <= rd_idx + 8'h01;
					end
					SEC_CMD_ARRAY_WRITE: begin
						page_base_reg <= rx_byte[7:4];
						col_reg       <= rx_byte[3:0];
					end
					default: begin
					end
				endcase
			end else begin
				case (cmd_reg)
					SEC_CMD_ARRAY_READ: begin
						addr_reg <= rd_idx + 8'h01;
					end
					SEC_CMD_ARRAY_WRITE: begin
						page_reg[col_reg] <= rx_byte;
						mask_reg[col_reg] <= 1'b1;
						col_reg           <= col_reg + 4'h1;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// next byte to send, reloaded at the opcode byte boundary and at each later byte boundary of a read
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			out_byte_reg <= 8'h00;
		end else if (byte_done) begin
			if (phase_reg == 2'h0) begin
				out_byte_reg <= st_now;
			end else if (cmd_reg == SEC_CMD_STATUS_READ) begin
				out_byte_reg <= st_now;
			end else if (cmd_reg == SEC_CMD_ARRAY_READ) begin
				out_byte_reg <= rd_data;
			end
		end
	end

	assign tx_on = (cmd_reg == SEC_CMD_STATUS_READ && phase_reg != 2'h0) ||
		(cmd_reg == SEC_CMD_ARRAY_READ && phase_reg >= 2'h2);

	// serial output on the falling edge
	always_ff @(negedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			so_reg    <= 1'b0;
			so_oe_reg <= 1'b0;
		end else if (tx_on) begin
			so_reg    <= out_byte_reg[~bit_cnt_reg];
			so_oe_reg <= 1'b1;
		end
	end

	assign so    = so_reg;
	assign so_oe = so_oe_reg;

	// system side synchronisers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cs_m1_reg  <= 1'b1;
			cs_s2_reg  <= 1'b1;
			cs_s3_reg  <= 1'b1;
			tog_m1_reg <= 1'b0;
			tog_s2_reg <= 1'b0;
			wp_m1_reg  <= 1'b1;
			wp_s2_reg  <= 1'b1;
		end else begin
			cs_m1_reg  <= cs_n;
			cs_s2_reg  <= cs_m1_reg;
			cs_s3_reg  <= cs_s2_reg;
			tog_m1_reg <= tog_reg;
			tog_s2_reg <= tog_m1_reg;
			wp_m1_reg  <= wp_n;
			wp_s2_reg  <= wp_m1_reg;
		end
	end

	assign busy    = (state_reg == SEC_ST_BUSY);
	assign hw_prot = ~wp_s2_reg & hw_en_reg;
	assign cs_rise = cs_s2_reg & ~cs_s3_reg;
	assign go      = cs_rise && (tog_s2_reg != tog_seen_reg) && !busy;
	assign finish  = busy && (cnt_reg == CNT_W'(1));

	// hw enable may only fall with the protect pin high
	assign hw_guard_enable_ok = ~(hw_en_reg & ~stat_data_reg[`SEC_ST_HWEN_BIT] & ~wp_s2_reg);

	assign start_stat = go && cmd_reg == SEC_CMD_STATUS_WRITE && stat_got_reg &&
		latch_reg && !hw_prot && hw_guard_enable_ok;
	assign start_arr = go && cmd_reg == SEC_CMD_ARRAY_WRITE && latch_reg &&
		(mask_reg != 16'h0000);

	// frame event bookkeeping
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tog_seen_reg <= 1'b0;
		end else if (cs_rise) begin
			tog_seen_reg <= tog_s2_reg;
		end
	end

	// write latch
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			latch_reg <= `SEC_LATCH_RST;
		end else if (go) begin
			case (cmd_reg)
				SEC_CMD_LATCH_SET: begin
					latch_reg <= 1'b1;
				end
				SEC_CMD_LATCH_CLEAR,
				SEC_CMD_STATUS_WRITE,
				SEC_CMD_ARRAY_WRITE: begin
					latch_reg <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// self-timed write cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= SEC_ST_IDLE;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				SEC_ST_IDLE: begin
					if (start_stat || start_arr) begin
						state_reg <= SEC_ST_BUSY;
						cnt_reg   <= CNT_W'(WR_CYCLES);
					end
				end
				SEC_ST_BUSY: begin
					cnt_reg <= cnt_reg - CNT_W'(1);
					if (finish) begin
						state_reg <= SEC_ST_IDLE;
					end
				end
				default: begin
					state_reg <= SEC_ST_IDLE;
				end
			endcase
		end
	end

	// pending status update, applied at the end of the cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pend_v_reg    <= 1'b0;
			pend_bp_reg   <= `SEC_BP_RST;
			pend_hwen_reg <= `SEC_HWEN_RST;
		end else if (start_stat) begin
			pend_v_reg    <= 1'b1;
			pend_bp_reg   <= {stat_data_reg[`SEC_ST_BP_HI_BIT],
				stat_data_reg[`SEC_ST_BP_LO_BIT]};
			pend_hwen_reg <= stat_data_reg[`SEC_ST_HWEN_BIT];
		end else if (finish) begin
			pend_v_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bp_reg    <= `SEC_BP_RST;
			hw_en_reg <= `SEC_HWEN_RST;
		end else if (finish && pend_v_reg) begin
			bp_reg    <= pend_bp_reg;
			hw_en_reg <= pend_hwen_reg;
		end
	end

	// guarded bytes are dropped from the page mask
	always_comb begin
		wmask = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			wmask[i] = mask_reg[i] & ~sec_guarded(bp_reg, {page_base_reg, 4'(i)});
		end
	end

	sec_array #(
		.ADDR_W (8),
		.PAGE_W (4)
	) u_array (
		.clk     (mclk),
		.we      (start_arr),
		.page    (page_base_reg),
		.wdata   (page_reg),
		.wmask   (wmask),
		.rd_idx  (rd_idx),
		.rd_data (rd_data)
	);
endmodule : sec_core

// ==== sec_core_asserts.sv ====
// port checks for the serial eeprom command core
`timescale 1ns/10ps
module sec_core_asserts #(
	parameter int WR_CYCLES = 20
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic wp_n,
	input wire logic so,
	input wire logic so_oe
);
	logic [4:0] cnt;
	logic [7:0] op;
	logic [7:0] opm;
	logic [7:0] sr;
	logic       rd_st;
	logic       rd_ar;
	logic       wr_op;
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) cnt <= 5'h00;
		else if (cnt != 5'h1F) cnt <= cnt + 5'h01;
	end
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) op <= 8'h00;
		else if (cnt < 5'h08) op <= {op[6:0], si};
	end
	always_ff @(posedge sck) sr <= {sr[6:0], so};
	assign opm   = op & 8'hF7;
	assign rd_st = opm == 8'h05;
	assign rd_ar = opm == 8'h03;
	assign wr_op = opm == 8'h06 || opm == 8'h04 || opm == 8'h01 || opm == 8'h02;
	property p_oe_late;
		@(negedge sck) disable iff (!rst_n) cnt <= 5'h08 |-> !so_oe;
	endproperty
	a_oe_late: assert property (p_oe_late) else $error("so driven in opcode");
	property p_st_oe;
		@(negedge sck) disable iff (!rst_n) rd_st && cnt >= 5'h09 |-> so_oe;
	endproperty
	a_st_oe: assert property (p_st_oe) else $error("status not driven");
	property p_wr_quiet;
		@(negedge sck) disable iff (!rst_n) wr_op && cnt >= 5'h09 |-> !so_oe;
	endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("so driven in write");
	property p_addr_quiet;
		@(negedge sck) disable iff (!rst_n) rd_ar && cnt <= 5'h10 |-> !so_oe;
	endproperty
	a_addr_quiet: assert property (p_addr_quiet) else $error("so driven in address");
	property p_cs_idle;
		@(posedge mclk) disable iff (!rst_n) cs_n |-> !so_oe;
	endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("so driven while deselected");
	property p_st_busy;
		@(negedge sck) disable iff (!rst_n) rd_st && cnt == 5'h10 && sr[0] |-> sr == 8'hFF;
	endproperty
	a_st_busy: assert property (p_st_busy) else $error("busy status not all ones");
	property p_st_idle;
		@(negedge sck) disable iff (!rst_n) rd_st && cnt == 5'h10 && !sr[0] |-> sr[6:4] == 3'h0;
	endproperty
	a_st_idle: assert property (p_st_idle) else $error("spare status bits set");
	property p_st_rep;
		@(negedge sck) disable iff (!rst_n)
			rd_st && cnt == 5'h18 && sr[0] == $past(sr[0], 8) |-> sr == $past(sr, 8);
	endproperty
	a_st_rep: assert property (p_st_rep) else $error("status byte not repeated");
	c_busy: cover property (@(negedge sck) rd_st && cnt == 5'h10 && sr == 8'hFF);
	c_read: cover property (@(negedge sck) rd_ar && cnt == 5'h11 && so_oe);
	c_wr: cover property (@(negedge sck) wr_op && cnt == 5'h10);
endmodule : sec_core_asserts
bind sec_core sec_core_asserts #(.WR_CYCLES(WR_CYCLES)) u_chk (.mclk(mclk), .rst_n(rst_n),
	.cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe));

// ==== sec_core_tb.sv ====
// self-checking bench for the serial eeprom command core
`timescale 1ns/10ps
module sec_core_tb;
	localparam int WRC = 60;
	logic       mclk;
	logic       rst_n;
	logic       wp_n;
	logic       cs_n;
	logic       sck;
	logic       si;
	logic       so;
	logic       so_oe;
	logic [7:0] tx [0:19];
	logic [7:0] rx [0:19];
	logic [7:0] mem [0:255];
	logic [7:0] ga [0:4];
	logic [7:0] est;
	int         fails;
	int         compares;
	int         cyc;
	sec_core #(.WR_CYCLES(WRC)) dut (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
		.si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe));
	sec_host u_host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic guarded(input logic [7:0] a);
		case (est[3:2])
			2'h0: return 1'b0;
			2'h1: return a >= 8'hC0;
			2'h2: return a >= 8'h80;
			default: return 1'b1;
		endcase
	endfunction : guarded
	task automatic cmd(input logic [7:0] o);
		tx[0] = o;
		u_host.xfer(1, tx, rx);
	endtask : cmd
	task automatic latch_on();
		cmd(8'h06);
		est[1] = 1'b1;
	endtask : latch_on
	task automatic settle();
		repeat (WRC + 8) @(posedge mclk);
	endtask : settle
	task automatic st_chk(input logic [7:0] e, input int n);
		int i;
		tx[0] = 8'h05;
		u_host.xfer(n + 1, tx, rx);
		for (i = 1; i <= n; i++) check("status", rx[i], e);
	endtask : st_chk
	task automatic wr_arr(input logic [7:0] a, input int n, input logic [7:0] d);
		int i;
		logic [7:0] ad;
		tx[0] = 8'h02;
		tx[1] = a;
		for (i = 0; i < n; i++) begin
			ad = {a[7:4], a[3:0] + i[3:0]};
			tx[i + 2] = d + i[7:0];
			if (est[1] && !guarded(ad)) mem[ad] = tx[i + 2];
		end
		u_host.xfer(n + 2, tx, rx);
		est[1] = 1'b0;
	endtask : wr_arr
	task automatic rd_arr(input logic [7:0] a, input int n);
		int i;
		logic [7:0] ad;
		tx[0] = 8'h03;
		tx[1] = a;
		u_host.xfer(n + 2, tx, rx);
		for (i = 0; i < n; i++) begin
			ad = a + i[7:0];
			check("array", rx[i + 2], mem[ad]);
		end
	endtask : rd_arr
	task automatic wr_st(input logic [7:0] d);
		logic ok;
		ok = est[1] && !(!wp_n && est[7]);
		tx[0] = 8'h01;
		tx[1] = d;
		u_host.xfer(2, tx, rx);
		settle();
		est[1] = 1'b0;
		if (ok) est = {d[7], 3'h0, d[3:2], 2'h0};
	endtask : wr_st
	task automatic t_latch();
		int i;
		for (i = 0; i < 2; i++) begin
			cmd({4'h0, i[0], 3'h6});
			st_chk(8'h02, 1);
			cmd({4'h0, i[0], 3'h4});
			st_chk(8'h00, 1);
		end
	endtask : t_latch
	task automatic t_page();
		latch_on();
		wr_arr(8'hFF, 1, 8'hA0);
		settle();
		latch_on();
		wr_arr(8'h0E, 18, 8'h40);
		st_chk(8'hFF, 2);
		cmd(8'h06);
		settle();
		st_chk(8'h00, 1);
		wr_arr(8'h05, 1, 8'h77);
		settle();
		rd_arr(8'hFF, 17);
	endtask : t_page
	task automatic t_guard();
		int b;
		int i;
		for (b = 0; b < 4; b++) begin
			latch_on();
			wr_st({4'h7, b[1:0], 2'h0});
			st_chk(est, 1);
			for (i = 0; i < 5; i++) begin
				latch_on();
				wr_arr(ga[i], 1, {b[3:0], i[3:0]});
				settle();
			end
			for (i = 0; i < 5; i++) rd_arr(ga[i], 1);
		end
	endtask : t_guard
	task automatic t_hw();
		latch_on();
		wr_st(8'h80);
		@(posedge mclk) wp_n <= 1'b0;
		repeat (4) @(posedge mclk);
		latch_on();
		wr_st(8'h0C);
		st_chk(est, 1);
		latch_on();
		wr_arr(8'h31, 1, 8'h5A);
		settle();
		rd_arr(8'h31, 1);
		@(posedge mclk) wp_n <= 1'b1;
		repeat (4) @(posedge mclk);
		latch_on();
		wr_st(8'h00);
		st_chk(est, 1);
		wr_st(8'h04);
		st_chk(est, 1);
	endtask : t_hw
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		wp_n = 1'b1;
		fails = 0;
		compares = 0;
		cyc = 0;
		est = 8'h00;
		ga = '{8'h00, 8'h7F, 8'h80, 8'hBF, 8'hC0};
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		st_chk(8'h00, 3);
		t_latch();
		t_page();
		t_guard();
		t_hw();
		print_verdict();
	end
endmodule : sec_core_tb

// ==== sec_host.sv ====
// serial bus controller model driving frames into the core
`timescale 1ns/10ps
module sec_host (
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	input  wire logic so,
	input  wire logic so_oe
);
	logic last;
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
		last = 1'b0;
	end
	task automatic xfer(input int n, input logic [7:0] tx [0:19], output logic [7:0] rx [0:19]);
		int i;
		int b;
		cs_n = 1'b0;
		#40;
		for (i = 0; i < n; i++) begin
			for (b = 7; b >= 0; b--) begin
				si = tx[i][b];
				#32 sck = 1'b1;
				rx[i][b] = so_oe ? so : ~last;
				last = rx[i][b];
				#32 sck = 1'b0;
			end
		end
		#20 cs_n = 1'b1;
		si = ~si;
		#300;
	endtask : xfer
endmodule : sec_host

// ==== sec_map.svh ====
// register map, opcodes and timing constants of the serial eeprom command core
// Function
// - eight-bit status register, read-only under hardware protection or cleared latch.
// - bit 0 reads 1 while busy; busy accepts only status read.
// - bit 1 is the write latch; latch-set sets it, reset clears it.
// - bits 2 and 3 are block guard bits, zero after reset.
// - during an internal write cycle every status bit reads 1.
// - bits 4 to 6 are not kept and read 0 when idle.
// - guard 00 none, 01 C0h-FFh, 10 80h-FFh, 11 whole array.
// - serial input sampled on rising clock, MSB first, opcode then operands.
// - serial output driven MSB first on the falling clock edge.
// - latch-set 0000X110, latch-clear 0000X100, status-read 0000X101, bit 3 ignored.
// - status-write 0000X001, array read 0000X011, array write 0000X010.
// - latch-clear, status-write and array-write all clear the write latch.
// - status-write keeps only guard and hw enable; needs latch, no hardware protection.
// - guard and hw enable bits change only when the status write cycle finishes.
// - hw guard enable may fall only while the protect pin is high.
// - hardware protection is active when protect pin low and hw enable set.
// - array read streams bytes, wrapping from last address to zero.
// - status read repeats the status byte while clocking continues.
// - array write stays inside a 16-byte page, wrapping; last 16 kept.
// - guarded bytes never change; others need latch; hw protection ignored.
`ifndef SEC_MAP_SVH
`define SEC_MAP_SVH

`define SEC_OP_LATCH_SET    3'h6
`define SEC_OP_LATCH_CLEAR  3'h4
`define SEC_OP_STATUS_READ  3'h5
`define SEC_OP_STATUS_WRITE 3'h1
`define SEC_OP_ARRAY_READ   3'h3
`define SEC_OP_ARRAY_WRITE  3'h2

`define SEC_ST_BUSY_BIT  0
`define SEC_ST_LATCH_BIT 1
`define SEC_ST_BP_LO_BIT 2
`define SEC_ST_BP_HI_BIT 3
`define SEC_ST_HWEN_BIT  7
`define SEC_ST_BUSY_VAL  8'hFF

`define SEC_GUARD_QTR  8'hC0
`define SEC_GUARD_HALF 8'h80

`define SEC_BP_RST    2'h0
`define SEC_HWEN_RST  1'b0
`define SEC_LATCH_RST 1'b0

`define SEC_WR_TIME_US 100
`define SEC_MCLK_KHZ   20000

`endif

// ==== sec_pkg.sv ====
// types and shared helpers of the serial eeprom command core
`include "sec_map.svh"
package sec_pkg;
	typedef enum logic [2:0] {
		SEC_CMD_NONE         = 3'h0,
		SEC_CMD_LATCH_SET    = 3'h1,
		SEC_CMD_LATCH_CLEAR  = 3'h2,
		SEC_CMD_STATUS_READ  = 3'h3,
		SEC_CMD_STATUS_WRITE = 3'h4,
		SEC_CMD_ARRAY_READ   = 3'h5,
		SEC_CMD_ARRAY_WRITE  = 3'h6
	} sec_cmd_e;

	typedef enum logic [1:0] {
		SEC_ST_IDLE = 2'h0,
		SEC_ST_BUSY = 2'h1
	} sec_state_e;

	function automatic sec_cmd_e sec_decode(input logic [7:0] op);
		sec_cmd_e c;
		c = SEC_CMD_NONE;
		if (op[7:4] == 4'h0) begin
			case (op[2:0])
				`SEC_OP_LATCH_SET:    c = SEC_CMD_LATCH_SET;
				`SEC_OP_LATCH_CLEAR:  c = SEC_CMD_LATCH_CLEAR;
				`SEC_OP_STATUS_READ:  c = SEC_CMD_STATUS_READ;
				`SEC_OP_STATUS_WRITE: c = SEC_CMD_STATUS_WRITE;
				`SEC_OP_ARRAY_READ:   c = SEC_CMD_ARRAY_READ;
				`SEC_OP_ARRAY_WRITE:  c = SEC_CMD_ARRAY_WRITE;
				default:              c = SEC_CMD_NONE;
			endcase
		end
		return c;
	endfunction : sec_decode

	function automatic logic sec_guarded(input logic [1:0] bp, input logic [7:0] addr);
		logic g;
		case (bp)
			2'h0:    g = 1'b0;
			2'h1:    g = (addr >= `SEC_GUARD_QTR);
			2'h2:    g = (addr >= `SEC_GUARD_HALF);
			default: g = 1'b1;
		endcase
		return g;
	endfunction : sec_guarded
endpackage : sec_pkg
